// [hw/hpp_pkg.sv]
/*
 * Shared constants and types for the host parallel port: register offsets, control bit
 * positions, access codes, FIFO sizing, state and carrier structs.
 * Assumes a 32-bit APB register bus and a simple request/acknowledge system interconnect.
 */
package hpp_pkg;

    localparam logic [7:0]  CTRL_OFS     = 8'h30;
    localparam logic [7:0]  WADDR_OFS    = 8'h34;
    localparam logic [7:0]  RADDR_OFS    = 8'h38;

    localparam logic [1:0]  ACC_CTRL     = 2'h0;
    localparam logic [1:0]  ACC_DATA_INC = 2'h1;
    localparam logic [1:0]  ACC_ADDR     = 2'h2;
    localparam logic [1:0]  ACC_DATA_FIX = 2'h3;

    localparam int          CB_READY     = 0;
    localparam int          CB_IRQ_CPU   = 1;
    localparam int          CB_IRQ_HOST  = 2;
    localparam int          CB_DUAL      = 3;
    localparam int          CB_ADDR_SEL  = 4;
    localparam int          CB_WIDE      = 5;
    localparam int          CB_WF_EMPTY  = 6;
    localparam int          CB_RF_EMPTY  = 7;

    localparam int          FIFO_DEPTH   = 8;
    localparam logic [3:0]  FIFO_FULL    = 4'h8;
    localparam logic [31:0] ADDR_STEP    = 32'h0000_0004;
    localparam int          SYNC_W       = 6;
    localparam logic [5:0]  SYNC_RST     = 6'h30;

    typedef enum logic [1:0] {
        DMA_IDLE  = 2'b00,
        DMA_WRITE = 2'b01,
        DMA_READ  = 2'b10
    } hpp_dma_t;

    typedef struct packed {
        logic       sel_n;
        logic       strobe_n;
        logic       rw_read;
        logic [1:0] acc;
        logic       hw_second;
    } hpp_host_ctl_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } hpp_sys_req_t;

    typedef struct packed {
        logic                             strap_done;
        logic                             wide;
        logic                             strb_prev;
        logic                             active;
        hpp_host_ctl_t                    cyc;
        logic                             ready;
        logic [31:0]                      bus_out;
        logic                             bus_oe;
        logic                             irq_to_host;
        logic                             irq_to_cpu;
        logic                             dual;
        logic                             addr_sel_rd;
        logic [31:0]                      waddr;
        logic [31:0]                      raddr;
        logic [15:0]                      hold;
        logic [FIFO_DEPTH-1:0][31:0]      wf;
        logic [2:0]                       wf_rd;
        logic [2:0]                       wf_wr;
        logic [3:0]                       wf_cnt;
        logic                             w_inc;
        logic [FIFO_DEPTH-1:0][31:0]      rf;
        logic [2:0]                       rf_rd;
        logic [2:0]                       rf_wr;
        logic [3:0]                       rf_cnt;
        logic                             r_inc;
        hpp_dma_t                         dma;
        hpp_sys_req_t                     sys;
        logic                             pready;
        logic [31:0]                      prdata;
        logic                             pslverr;
    } hpp_state_t;

    localparam hpp_state_t STATE_RST = '0;

endpackage

// [hw/hpp_sync.sv]
/*
 * Two-stage level synchronizer for a group of asynchronous inputs.
 * Assumes the inputs are levels that stay stable for several clock periods.
 */
`timescale 1ns/1ps
module hpp_sync #(
    parameter int               W   = 1,
    parameter logic [W-1:0]     RST = '0
) (
    input  wire logic           i_clk,
    input  wire logic           i_nrst,
    input  wire logic [W-1:0]   i_d,
    output logic      [W-1:0]   o_q
);
    logic [1:0][W-1:0] st_r;
    logic [1:0][W-1:0] st_nxt;

    // Only the second stage is visible outside.
    always_comb begin
        st_nxt = {st_r[0], i_d};
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_r <= {RST, RST};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_q = st_r[1];
endmodule // hpp_sync

// [hw/hpp_host_port.sv]
/*
 * Host parallel port: multiplexed 16/32-bit host slave, APB control slave for the CPU,
 * write and read FIFOs and a fixed transfer engine on the system interconnect.
 * Assumes the host holds bus data for at least three clocks after a strobe edge.
 */
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module hpp_host_port (
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_nrst,
    input  wire logic                   i_bus_width_strap,
    input  wire logic                   i_port_select_n,
    input  wire logic                   i_data_strobe_n,
    input  wire logic                   i_rw_direction,
    input  wire logic [1:0]             i_access_select,
    input  wire logic                   i_halfword_id_in,
    input  wire logic [31:0]            i_host_muxed_bus_in,
    output logic      [31:0]            o_host_muxed_bus_out,
    output logic                        o_host_muxed_bus_oe,
    output logic                        o_host_ready_out,
    output logic                        o_irq_to_host,
    output logic                        o_irq_to_cpu,
    input  wire logic                   i_psel,
    input  wire logic                   i_penable,
    input  wire logic                   i_pwrite,
    input  wire logic [31:0]            i_paddr,
    input  wire logic [31:0]            i_pwdata,
    output logic      [31:0]            o_prdata,
    output logic                        o_pready,
    output logic                        o_pslverr,
    output hpp_pkg::hpp_sys_req_t       o_sys_cmd,
    input  wire logic                   i_sys_ack,
    input  wire logic [31:0]            i_sys_rdata
);
    import hpp_pkg::*;

    hpp_state_t     s_r;
    hpp_state_t     s_nxt;
    hpp_host_ctl_t  h;
    logic [5:0]     h_raw;
    logic           fall;
    logic           rise;
    logic           last_half;
    logic           inc;
    logic           can;
    logic           dma_quiet;
    logic           w_push;
    logic           w_pop;
    logic           r_push;
    logic           r_pop;
    logic           rf_flush;
    logic           apb_map;
    logic           apb_done;
    logic           low_half;
    logic           irq_cpu_set;
    logic           irq_cpu_clr;
    logic           irq_host_set;
    logic           irq_host_clr;
    logic [31:0]    word_in;
    logic [31:0]    ctrl_word;
    logic [31:0]    rd_word;

    ////////////////////////////////////////////////////////////////////////////////////////
    hpp_sync #(
        .W   (SYNC_W),
        .RST (SYNC_RST)
    ) u_sync (
        .i_clk  (i_sys_clk),
        .i_nrst (i_nrst),
        .i_d    ({i_port_select_n, i_data_strobe_n, i_rw_direction,
                  i_access_select, i_halfword_id_in}),
        .o_q    (h_raw)
    );

    assign h = hpp_host_ctl_t'(h_raw);

    ////////////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_nxt        = s_r;
        w_push       = 1'b0;
        w_pop        = 1'b0;
        r_push       = 1'b0;
        r_pop        = 1'b0;
        rf_flush     = 1'b0;
        irq_cpu_set  = 1'b0;
        irq_cpu_clr  = 1'b0;
        irq_host_set = 1'b0;
        irq_host_clr = 1'b0;

        // The strap is caught on the first edge after reset release, never by the reset.
        if (!s_r.strap_done) begin
            s_nxt.strap_done = 1'b1;
            s_nxt.wide       = i_bus_width_strap;
        end

        fall            = s_r.strb_prev & ~h.strobe_n;
        rise            = ~s_r.strb_prev & h.strobe_n;
        s_nxt.strb_prev = h.strobe_n;
        last_half       = s_r.wide | s_r.cyc.hw_second;
        low_half        = s_r.wide | ~s_r.cyc.hw_second;
        inc             = (s_r.cyc.acc == ACC_DATA_INC);
        dma_quiet       = (s_r.dma == DMA_IDLE) && (s_r.wf_cnt == 4'h0);
        word_in         = s_r.wide ? i_host_muxed_bus_in
                                   : {i_host_muxed_bus_in[15:0], s_r.hold};

        ctrl_word              = 32'h0000_0000;
        ctrl_word[CB_READY]    = s_r.ready;
        ctrl_word[CB_IRQ_CPU]  = s_r.irq_to_cpu;
        ctrl_word[CB_IRQ_HOST] = s_r.irq_to_host;
        ctrl_word[CB_DUAL]     = s_r.dual;
        ctrl_word[CB_ADDR_SEL] = s_r.addr_sel_rd;
        ctrl_word[CB_WIDE]     = s_r.wide;
        ctrl_word[CB_WF_EMPTY] = (s_r.wf_cnt == 4'h0);
        ctrl_word[CB_RF_EMPTY] = (s_r.rf_cnt == 4'h0);

        // A cycle opens at the strobe's falling edge, and only while selected.
        if (fall && !h.sel_n) begin
            s_nxt.active = 1'b1;
            s_nxt.cyc    = h;
            if (h.rw_read && h.acc[0]) begin
                s_nxt.r_inc = (h.acc == ACC_DATA_INC);
            end
        end

        unique case (s_r.cyc.acc)
            ACC_CTRL: begin
                can     = 1'b1;
                rd_word = ctrl_word;
            end
            ACC_ADDR: begin
                // Address changes wait for the engine so no transfer sees a torn address.
                can     = dma_quiet;
                rd_word = (s_r.dual && s_r.addr_sel_rd) ? s_r.raddr : s_r.waddr;
            end
            ACC_DATA_INC, ACC_DATA_FIX: begin
                if (s_r.cyc.rw_read) begin
                    can = (s_r.rf_cnt != 4'h0);
                end else begin
                    can = !last_half || (inc ? (s_r.wf_cnt != FIFO_FULL) : dma_quiet);
                end
                rd_word = s_r.rf[s_r.rf_rd];
            end
        endcase

        s_nxt.ready   = ~s_r.active | can;
        s_nxt.bus_oe  = s_r.active & s_r.cyc.rw_read;
        s_nxt.bus_out = s_r.wide ? rd_word
                      : (s_r.cyc.hw_second ? {16'h0000, rd_word[31:16]}
                                           : {16'h0000, rd_word[15:0]});

        // A cycle completes at the strobe's rising edge.
        if (rise && s_r.active) begin
            s_nxt.active = 1'b0;
            if (!s_r.cyc.rw_read) begin
                if (!last_half) begin
                    s_nxt.hold = i_host_muxed_bus_in[15:0];
                end
                unique case (s_r.cyc.acc)
                    ACC_CTRL: begin
                        if (low_half) begin
                            s_nxt.dual        = i_host_muxed_bus_in[CB_DUAL];
                            s_nxt.addr_sel_rd = i_host_muxed_bus_in[CB_ADDR_SEL];
                            irq_cpu_set       = i_host_muxed_bus_in[CB_IRQ_CPU];
                            irq_host_clr      = i_host_muxed_bus_in[CB_IRQ_HOST];
                        end
                    end
                    ACC_ADDR: begin
                        if (last_half) begin
                            if (!s_r.dual || !s_r.addr_sel_rd) begin
                                s_nxt.waddr = word_in;
                            end
                            if (!s_r.dual || s_r.addr_sel_rd) begin
                                s_nxt.raddr = word_in;
                                s_nxt.r_inc = 1'b0;
                                rf_flush    = 1'b1;
                            end
                        end
                    end
                    ACC_DATA_INC, ACC_DATA_FIX: begin
                        if (last_half && can) begin
                            w_push      = 1'b1;
                            s_nxt.w_inc = inc;
                        end
                    end
                endcase
            end else if (s_r.cyc.acc[0] && last_half && (s_r.rf_cnt != 4'h0)) begin
                r_pop = 1'b1;
            end
        end

        // Writes drain before any fetch, so a read never overtakes host write data.
        unique case (s_r.dma)
            DMA_IDLE: begin
                if (s_r.wf_cnt != 4'h0) begin
                    s_nxt.dma       = DMA_WRITE;
                    s_nxt.sys.req   = 1'b1;
                    s_nxt.sys.we    = 1'b1;
                    s_nxt.sys.addr  = s_r.waddr;
                    s_nxt.sys.wdata = s_r.wf[s_r.wf_rd];
                end else if ((s_r.rf_cnt != FIFO_FULL) && (s_r.r_inc
                             || (s_r.active && s_r.cyc.rw_read && s_r.cyc.acc[0]
                                 && (s_r.rf_cnt == 4'h0)))) begin
                    s_nxt.dma      = DMA_READ;
                    s_nxt.sys.req  = 1'b1;
                    s_nxt.sys.we   = 1'b0;
                    s_nxt.sys.addr = s_r.raddr;
                end
            end
            DMA_WRITE: begin
                if (i_sys_ack) begin
                    s_nxt.dma     = DMA_IDLE;
                    s_nxt.sys.req = 1'b0;
                    w_pop         = 1'b1;
                    if (s_r.w_inc) begin
                        s_nxt.waddr = s_r.waddr + ADDR_STEP;
                    end
                end
            end
            DMA_READ: begin
                if (i_sys_ack) begin
                    s_nxt.dma     = DMA_IDLE;
                    s_nxt.sys.req = 1'b0;
                    r_push        = 1'b1;
                    if (s_r.r_inc) begin
                        s_nxt.raddr = s_r.raddr + ADDR_STEP;
                    end
                end
            end
            default: begin
                s_nxt.dma     = DMA_IDLE;
                s_nxt.sys.req = 1'b0;
            end
        endcase

        ////////////////////////////////////////////////////////////////////////////////////
        if (w_push) begin
            s_nxt.wf[s_r.wf_wr] = word_in;
            s_nxt.wf_wr         = s_r.wf_wr + 3'h1;
        end
        if (w_pop) begin
            s_nxt.wf_rd = s_r.wf_rd + 3'h1;
        end
        s_nxt.wf_cnt = s_r.wf_cnt + {3'h0, w_push} - {3'h0, w_pop};
        if (r_push) begin
            s_nxt.rf[s_r.rf_wr] = i_sys_rdata;
            s_nxt.rf_wr         = s_r.rf_wr + 3'h1;
        end
        if (r_pop) begin
            s_nxt.rf_rd = s_r.rf_rd + 3'h1;
        end
        s_nxt.rf_cnt = s_r.rf_cnt + {3'h0, r_push} - {3'h0, r_pop};
        if (rf_flush) begin
            s_nxt.rf_rd  = 3'h0;
            s_nxt.rf_wr  = 3'h0;
            s_nxt.rf_cnt = 4'h0;
        end

        ////////////////////////////////////////////////////////////////////////////////////
        // One wait state keeps read data and pready straight from flip-flops.
        apb_map      = (i_paddr[7:0] == CTRL_OFS) || (i_paddr[7:0] == WADDR_OFS)
                    || (i_paddr[7:0] == RADDR_OFS);
        apb_done     = i_psel & i_penable & s_r.pready;
        s_nxt.pready = i_psel & i_penable & ~s_r.pready;
        if (i_psel && i_penable && !s_r.pready) begin
            s_nxt.pslverr = ~apb_map;
            case (i_paddr[7:0])
                CTRL_OFS:  s_nxt.prdata = ctrl_word;
                WADDR_OFS: s_nxt.prdata = s_r.waddr;
                RADDR_OFS: s_nxt.prdata = s_r.raddr;
                default:   s_nxt.prdata = 32'h0000_0000;
            endcase
        end
        if (apb_done && i_pwrite && (i_paddr[7:0] == CTRL_OFS)) begin
            irq_host_set = i_pwdata[CB_IRQ_HOST];
            irq_cpu_clr  = i_pwdata[CB_IRQ_CPU];
        end

        // A set in the same cycle as a clear wins.
        s_nxt.irq_to_host = (s_r.irq_to_host & ~irq_host_clr) | irq_host_set;
        s_nxt.irq_to_cpu  = (s_r.irq_to_cpu & ~irq_cpu_clr) | irq_cpu_set;
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_r <= STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    assign o_host_muxed_bus_out = s_r.bus_out;
    assign o_host_muxed_bus_oe  = s_r.bus_oe;
    assign o_host_ready_out     = s_r.ready;
    assign o_irq_to_host        = s_r.irq_to_host;
    assign o_irq_to_cpu         = s_r.irq_to_cpu;
    assign o_prdata             = s_r.prdata;
    assign o_pready             = s_r.pready;
    assign o_pslverr            = s_r.pslverr;
    assign o_sys_cmd            = s_r.sys;
endmodule // hpp_host_port

// [tb/hpp_host_port_properties.sv]
/* Port-level checks for the host parallel port.
   Assumes binding into hpp_host_port. */
`timescale 1ns/1ps
module hpp_host_port_properties
    import hpp_pkg::*;
(
    input wire logic         i_sys_clk,
    input wire logic         i_nrst,
    input wire logic         i_bus_width_strap,
    input wire logic         i_port_select_n,
    input wire logic         i_data_strobe_n,
    input wire logic         i_rw_direction,
    input wire logic         i_psel,
    input wire logic         i_penable,
    input wire logic         i_pwrite,
    input wire logic [31:0]  i_paddr,
    input wire logic [31:0]  i_pwdata,
    input wire logic [31:0]  o_prdata,
    input wire logic         o_pready,
    input wire logic         o_pslverr,
    input wire logic [31:0]  o_host_muxed_bus_out,
    input wire logic         o_host_muxed_bus_oe,
    input wire logic         o_host_ready_out,
    input wire logic         o_irq_to_host,
    input wire logic         o_irq_to_cpu,
    input wire hpp_sys_req_t o_sys_cmd,
    input wire logic         i_sys_ack
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    logic bad_ofs;
    logic ctl_wr;
    assign bad_ofs = !(i_paddr[7:0] inside {CTRL_OFS, WADDR_OFS, RADDR_OFS});
    assign ctl_wr = i_psel && i_penable && o_pready && i_pwrite && i_paddr[7:0] == CTRL_OFS;
    ////////////////////////////////////////////////////////////////
    a_apb_one_wait: assert property ($rose(i_penable) && i_psel |-> !o_pready ##1 o_pready)
        else $error("wait state");
    a_pready_pulse: assert property (o_pready |=> !o_pready)
        else $error("pready held");
    a_apb_unmapped: assert property (o_pready && bad_ofs |-> o_pslverr && o_prdata == 32'h0000_0000)
        else $error("no slverr");
    a_irq_host_set: assert property (ctl_wr && i_pwdata[CB_IRQ_HOST] |=> o_irq_to_host)
        else $error("no host irq");
    a_irq_cpu_clr: assert property (ctl_wr && i_pwdata[CB_IRQ_CPU] |=> !o_irq_to_cpu)
        else $error("cpu irq kept");
    a_req_hold: assert property (o_sys_cmd.req && !i_sys_ack |=> o_sys_cmd.req && $stable(o_sys_cmd))
        else $error("req changed");
    a_req_drop: assert property (o_sys_cmd.req && i_sys_ack |=> !o_sys_cmd.req)
        else $error("req held");
    a_oe_after_strobe: assert property ($rose(o_host_muxed_bus_oe) |->
        $past(i_data_strobe_n, 3) == 1'b0 && !i_port_select_n)
        else $error("oe no strobe");
    a_oe_read_only: assert property (o_host_muxed_bus_oe |-> i_rw_direction)
        else $error("oe on write");
    a_half_upper: assert property (o_host_muxed_bus_oe && !i_bus_width_strap |->
        o_host_muxed_bus_out[31:16] == 16'h0000)
        else $error("upper half");
    c_apb_err: cover property (o_pready && o_pslverr);
    c_sys_write: cover property (o_sys_cmd.req && o_sys_cmd.we && i_sys_ack);
    c_host_read: cover property ($rose(o_host_muxed_bus_oe));
    c_not_ready: cover property (!o_host_ready_out);
endmodule // hpp_host_port_properties

bind hpp_host_port hpp_host_port_properties u_hpp_host_port_properties (.*);

// [tb/hpp_host_model.sv]
/* Behavioural external host, one port cycle per call.
   Assumes calls from a single process. */
`timescale 1ns/1ps
module hpp_host_model (
    input  wire logic        i_clk,
    input  wire logic        i_ready,
    input  wire logic [31:0] i_bus,
    output logic             o_sel_n,
    output logic             o_strobe_n,
    output logic             o_rw,
    output logic [1:0]       o_acc,
    output logic             o_hw,
    output logic [31:0]      o_bus
);
    int waits = 0;
    initial begin
        o_sel_n = 1'b1;
        o_strobe_n = 1'b1;
        o_rw = 1'b1;
        o_acc = 2'h0;
        o_hw = 1'b0;
        o_bus = 32'h0000_0000;
    end

    task automatic cyc(input logic s, input logic r, input logic [1:0] a, input logic h,
                       input logic [31:0] d, output logic [31:0] q, output logic ok);
        int n;
        n = 0;
        @(posedge i_clk);
        o_sel_n <= s;
        o_rw <= r;
        o_acc <= a;
        o_hw <= h;
        o_bus <= d;
        o_strobe_n <= 1'b0;
        repeat (5) @(posedge i_clk);
        do begin
            @(posedge i_clk);
            n++;
        end while (!i_ready && n < 300);
        q = i_bus;
        ok = (n < 300);
        waits = n;
        o_strobe_n <= 1'b1;
        repeat (6) @(posedge i_clk);
        o_sel_n <= 1'b1;
        o_bus <= ~d;
        repeat (3) @(posedge i_clk);
    endtask
endmodule // hpp_host_model

// [tb/hpp_host_port_test.sv]
/* Self-checking bench for the host parallel port.
   Assumes a 10 MHz clock. */
`timescale 1ns/1ps
module hpp_host_port_test;
    import hpp_pkg::*;
    logic         i_sys_clk = 1'b0;
    logic         i_nrst = 1'b0;
    logic         strap = 1'b1;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [31:0]  paddr = 32'h0000_0000;
    logic [31:0]  pwdata = 32'h0000_0000;
    logic         sys_ack = 1'b0;
    logic [31:0]  sys_rdata = 32'h0000_0000;
    logic [31:0]  prdata, bus_out, hbus, rd;
    logic         pready, pslverr, bus_oe, rdy, irq_h, irq_c, err;
    logic         sel_n, stb_n, rw, hw;
    logic [1:0]   acc;
    hpp_sys_req_t cmd;
    int           num_errors = 0;
    int           n_compared = 0;
    int           ack_dly = 1;
    int           wcnt = 0;
    int           nwr = 0;
    logic [31:0]  mem [logic [31:0]];

    always #50 i_sys_clk = ~i_sys_clk;

    hpp_host_port u_hpp_host_port (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
        .i_bus_width_strap(strap), .i_port_select_n(sel_n), .i_data_strobe_n(stb_n),
        .i_rw_direction(rw), .i_access_select(acc), .i_halfword_id_in(hw),
        .i_host_muxed_bus_in(hbus), .o_host_muxed_bus_out(bus_out),
        .o_host_muxed_bus_oe(bus_oe), .o_host_ready_out(rdy), .o_irq_to_host(irq_h),
        .o_irq_to_cpu(irq_c), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_sys_cmd(cmd), .i_sys_ack(sys_ack), .i_sys_rdata(sys_rdata));
    hpp_host_model u_hpp_host_model (.i_clk(i_sys_clk), .i_ready(rdy), .i_bus(bus_out),
        .o_sel_n(sel_n), .o_strobe_n(stb_n), .o_rw(rw), .o_acc(acc), .o_hw(hw), .o_bus(hbus));

    // Read data is scrambled outside acknowledge cycles.
    always @(posedge i_sys_clk) begin
        sys_ack <= 1'b0;
        sys_rdata <= ~sys_rdata;
        if (cmd.req && !sys_ack) begin
            if (wcnt >= ack_dly) begin
                sys_ack <= 1'b1;
                wcnt <= 0;
                if (cmd.we) begin
                    mem[cmd.addr] = cmd.wdata;
                    nwr++;
                end else begin
                    sys_rdata <= mem.exists(cmd.addr) ? mem[cmd.addr] : ~cmd.addr;
                end
            end else begin
                wcnt <= wcnt + 1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {24'h00_0000, a};
        pwdata <= d;
        @(posedge i_sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (!pready && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge i_sys_clk);
        if (n >= 50) num_errors++;
    endtask
    task automatic hcyc(input logic s, input logic r, input logic [1:0] a, input logic h,
                        input logic [31:0] d);
        logic ok;
        u_hpp_host_model.cyc(s, r, a, h, d, rd, ok);
        if (!ok) num_errors++;
    endtask
    task automatic set_addr(input logic [31:0] a);
        repeat (40) @(posedge i_sys_clk);
        if (strap) begin
            hcyc(1'b0, 1'b0, ACC_ADDR, 1'b0, a);
        end else begin
            hcyc(1'b0, 1'b0, ACC_ADDR, 1'b0, {16'h0000, a[15:0]});
            hcyc(1'b0, 1'b0, ACC_ADDR, 1'b1, {16'h0000, a[31:16]});
        end
    endtask
    task automatic wait_wr(input int n);
        int k;
        k = 0;
        while (nwr < n && k < 500) begin
            @(posedge i_sys_clk);
            k++;
        end
        if (k >= 500) num_errors++;
    endtask
    task automatic reset_dut(input logic s);
        @(posedge i_sys_clk);
        i_nrst <= 1'b0;
        strap <= s;
        repeat (2) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_regs;
        apb(1'b0, CTRL_OFS, 32'h0000_0000);
        chk(32'(rd[CB_WIDE]), 32'h0000_0001);
        apb(1'b1, WADDR_OFS, 32'h1234_5678);
        apb(1'b0, WADDR_OFS, 32'h0000_0000);
        chk({rd[30:0], err}, 32'h0000_0000);
        apb(1'b0, 8'h3C, 32'h0000_0000);
        chk({rd[30:0], err}, 32'h0000_0001);
        apb(1'b1, CTRL_OFS, 32'h0000_0004);
        chk(32'(irq_h), 32'h0000_0001);
    endtask
    task automatic t_ctrl;
        hcyc(1'b0, 1'b0, ACC_CTRL, 1'b0, 32'h0000_0006);
        chk({30'h0, irq_c, irq_h}, 32'h0000_0002);
        hcyc(1'b0, 1'b1, ACC_CTRL, 1'b0, 32'h0000_0000);
        chk(32'(rd[CB_IRQ_CPU]), 32'h0000_0001);
        apb(1'b1, CTRL_OFS, 32'h0000_0002);
        chk(32'(irq_c), 32'h0000_0000);
    endtask
    task automatic t_busy;
        int b;
        b = nwr;
        set_addr(32'h0000_0300);
        ack_dly = 30;
        hcyc(1'b0, 1'b0, ACC_DATA_FIX, 1'b0, 32'h0BAD_F00D);
        hcyc(1'b0, 1'b0, ACC_DATA_FIX, 1'b0, 32'h600D_F00D);
        chk(32'(u_hpp_host_model.waits > 1), 32'h0000_0001);
        wait_wr(b + 2);
        ack_dly = 1;
        chk(mem[32'h0000_0300], 32'h600D_F00D);
    endtask
    task automatic t_wr_burst;
        int b;
        b = nwr;
        set_addr(32'h0000_0100);
        hcyc(1'b0, 1'b0, ACC_DATA_INC, 1'b0, 32'hA5A5_0001);
        hcyc(1'b0, 1'b0, ACC_DATA_INC, 1'b1, 32'h5A5A_0002);
        hcyc(1'b0, 1'b0, ACC_DATA_INC, 1'b0, 32'hC3C3_0003);
        wait_wr(b + 3);
        chk(mem[32'h0000_0100], 32'hA5A5_0001);
        chk(mem[32'h0000_0104], 32'h5A5A_0002);
        chk(mem[32'h0000_0108], 32'hC3C3_0003);
        apb(1'b0, WADDR_OFS, 32'h0000_0000);
        chk(rd, 32'h0000_010C);
    endtask
    task automatic t_rd_burst;
        mem[32'h0000_0200] = 32'h1111_2222;
        mem[32'h0000_0204] = 32'h3333_4444;
        set_addr(32'h0000_0200);
        hcyc(1'b0, 1'b1, ACC_DATA_INC, 1'b0, 32'h0000_0000);
        chk(rd, 32'h1111_2222);
        hcyc(1'b0, 1'b1, ACC_DATA_INC, 1'b0, 32'h0000_0000);
        chk(rd, 32'h3333_4444);
    endtask
    task automatic t_sel;
        int b;
        b = nwr;
        hcyc(1'b1, 1'b0, ACC_DATA_INC, 1'b0, 32'hDEAD_0000);
        repeat (20) @(posedge i_sys_clk);
        chk(32'(nwr), 32'(b));
    endtask
    task automatic t_half;
        int b;
        reset_dut(1'b0);
        apb(1'b0, CTRL_OFS, 32'h0000_0000);
        chk(32'(rd[CB_WIDE]), 32'h0000_0000);
        b = nwr;
        set_addr(32'h0000_0400);
        hcyc(1'b0, 1'b0, ACC_DATA_INC, 1'b0, 32'h0000_BEEF);
        hcyc(1'b0, 1'b0, ACC_DATA_INC, 1'b1, 32'h0000_DEAD);
        wait_wr(b + 1);
        chk(mem[32'h0000_0400], 32'hDEAD_BEEF);
        set_addr(32'h0000_0400);
        hcyc(1'b0, 1'b1, ACC_DATA_INC, 1'b0, 32'h0000_0000);
        chk(rd, 32'h0000_BEEF);
        hcyc(1'b0, 1'b1, ACC_DATA_INC, 1'b1, 32'h0000_0000);
        chk(rd, 32'h0000_DEAD);
    endtask
    task automatic close_out;
        if (num_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        reset_dut(1'b1);
        t_regs;
        t_ctrl;
        t_busy;
        t_wr_burst;
        t_rd_burst;
        t_sel;
        t_half;
        close_out;
    end
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        num_errors++;
        close_out;
    end
endmodule // hpp_host_port_test
